// ### rtl/tcd_pkg.sv
package tcd_pkg;
  // Clock and millisecond pacing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int QUEUE_DEPTH = 8;
  localparam int START_WAIT = 3;
  // Boundary counters
  localparam logic [9:0] MS_LAST = 10'h3E7;
  localparam logic [4:0] CNT21_LAST = 5'h14;
  localparam logic [6:0] CNT100_LAST = 7'h63;
  localparam logic [1:0] ALIVE_SECS = 2'h2;
  // Telecommand layout
  localparam logic [11:0] TC_PREFIX = 12'hC00;
  localparam logic [3:0] Z_Q0 = 4'h0;
  localparam logic [3:0] Z_Q1 = 4'h2;
  localparam logic [3:0] Z_Q2 = 4'h4;
  localparam logic [3:0] Z_Q3 = 4'h6;
  localparam logic [3:0] Z_ALL = 4'h8;
  localparam logic [3:0] Z_HWCFG = 4'hA;
  localparam logic [7:0] HW_PROC_RESET = 8'h00;
  localparam logic [7:0] HW_PROC_RELEASE = 8'h01;
  localparam logic [7:0] HW_QCMD_ON = 8'h20;
  localparam logic [7:0] HW_QCMD_OFF = 8'h21;
  localparam logic [7:0] HW_ECC_ON = 8'h30;
  localparam logic [7:0] HW_ECC_OFF = 8'h31;
  localparam logic [7:0] HW_WDOG_ON = 8'h40;
  localparam logic [7:0] HW_WDOG_OFF = 8'h41;
  // Quadrant command words
  localparam logic [15:0] QC_INIT = 16'h00F0;
  localparam logic [15:0] QC_RST_REL = 16'h00F1;
  localparam logic [15:0] QC_DET_EVENT = 16'h00F2;
  localparam logic [15:0] QC_FEB_EVENT = 16'h00F3;
  localparam logic [15:0] QC_HV_ON = 16'h00F4;
  // Status input fields
  localparam int WDC_MSB = 13;
  localparam int WDC_LSB = 9;
  // Values after power-on
  localparam logic CMD_EN_RST = 1'b1;
  localparam logic ECC_EN_RST = 1'b1;
  localparam logic WDOG_EN_RST = 1'b1;
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_TIME_SEC = 8'h00;
  localparam logic [7:0] A_TIME_MS = 8'h04;
  localparam logic [7:0] A_CFG = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_HK = 8'h10;
  localparam logic [7:0] A_QSTAT0 = 8'h14;
  localparam logic [7:0] A_QSTAT1 = 8'h18;
  localparam logic [7:0] A_QSTAT2 = 8'h1C;
  localparam logic [7:0] A_QSTAT3 = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_START = 2'h0,
    ST_IDLE = 2'h1,
    ST_INIT1 = 2'h3,
    ST_INIT2 = 2'h2
  } tcd_state_t;
endpackage

// ### rtl/tcd_top.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Millisecond counter runs 0 to 999, wraps.
// - 32-bit seconds count advances on each wrap.
// - Detect 21 ms, 1 s, 100 s boundaries.
// - Tick logic raises a flag per boundary.
// - Sense arrivals per ms, decode at second.
// - Upper word 0xC00Z selects quadrant or all.
// - Forward low word, update quadrant status words.
// - Queue command word with its quadrant map.
// - Send one queued command per millisecond tick.
// - Forward and update only for alive quadrants.
// - Alive after two data seconds, dead after one.
// - Init: reset release, detector event, front end.
// - Drop high-voltage-on while radiation zone set.
// - Commanding disabled blocks forwarding and status updates.
// - 0xC00A 00YY is hardware configuration, listed YY.
// - Nonzero restart count restores saved state.
// - Save status variables every second, not cleared.
// - Power-on clears telemetry and status storage.
// - Watchdog restart keeps telemetry and quadrant status.
// - Restart count sits in status bits 13:9.
// - Code 0020 enables quadrant commanding, 0021 disables.
module tcd_top import tcd_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter int QDEPTH = QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Telecommand pins from the bus management unit
  input wire logic tc_strobe,
  input wire logic [31:0] tc_word,
  // Status word and radiation zone pins
  input wire logic [15:0] status_word,
  input wire logic radiation_zone,
  // Quadrant link
  input wire logic [3:0] q_data_seen,
  output logic [3:0] q_cmd_stb,
  output logic [15:0] q_cmd_word,
  output logic sec_cmd_stb,
  // Timebase
  output logic ms_tick,
  output logic flag_21ms,
  output logic flag_sec,
  output logic flag_100s,
  output logic [31:0] sys_time,
  // Hardware configuration
  output logic quad_cmd_en,
  output logic ecc_en,
  output logic wdog_en,
  output logic proc_hold,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int DIVW = $clog2(MS_CYC);
  localparam int PW = $clog2(QDEPTH);

  typedef struct packed {
    logic tc_s1, tc_s2, tc_s3;
    logic [31:0] tw_s1, tw_s2;
    logic [15:0] sw_s1, sw_s2;
    logic rz_s1, rz_s2;
    logic [3:0] qd_s1, qd_s2;
    logic [DIVW-1:0] div;
    logic [9:0] ms;
    logic [4:0] c21;
    logic [6:0] c100;
    logic [31:0] sec;
    logic ms_tick, f21, fsec, f100, sec_stb;
    logic arrived, pend;
    logic [31:0] arr_word, held;
    tcd_state_t st;
    logic [1:0] start_cnt;
    logic wd_restart;
    logic cmd_en, ecc_en, wdog_en, proc_hold;
    logic [3:0] alive, seen, init_map;
    logic [3:0][1:0] streak;
    logic [3:0][15:0] q_stat;
    logic [15:0] hk;
    logic ovf;
    logic [QDEPTH-1:0][19:0] q_mem;
    logic [PW-1:0] wp, rp;
    logic [PW:0] cnt;
    logic [3:0] q_stb;
    logic [15:0] q_word;
    logic awready, wready, bvalid, arready, rvalid, aw_got, w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
  } tcd_regs_t;

  // Kept across a watchdog restart, so it has no reset
  typedef struct packed {
    logic cmd_en, ecc_en, wdog_en, proc_hold;
    logic [3:0] alive;
    logic [3:0][1:0] streak;
    logic [3:0][15:0] q_stat;
    logic [15:0] hk;
  } tcd_keep_t;

  tcd_regs_t r_r, r_nxt;
  tcd_keep_t keep_r;
  logic rs_meta_r, rst_n_r;
  logic ms_evt, sec_evt, push, push_ok, pop, full, save_en;
  logic [19:0] push_ent;
  logic [3:0] zmap, fmap;
  logic [15:0] lo;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == A_TIME_SEC) || (a == A_TIME_MS) || (a == A_CFG) || (a == A_STATUS) || (a == A_HK) ||
             (a == A_QSTAT0) || (a == A_QSTAT1) || (a == A_QSTAT2) || (a == A_QSTAT3);
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rs_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rs_meta_r <= 1'b1;
      rst_n_r <= rs_meta_r;
    end
  end

  always_comb begin
    r_nxt = r_r;
    push = 1'b0;
    push_ent = 20'h0_0000;
    zmap = 4'h0;
    fmap = 4'h0;
    lo = r_r.held[15:0];
    full = (r_r.cnt == (PW+1)'(QDEPTH));
    // Pin synchronisers, two flops before any logic
    r_nxt.tc_s1 = tc_strobe;
    r_nxt.tc_s2 = r_r.tc_s1;
    r_nxt.tc_s3 = r_r.tc_s2;
    r_nxt.tw_s1 = tc_word;
    r_nxt.tw_s2 = r_r.tw_s1;
    r_nxt.sw_s1 = status_word;
    r_nxt.sw_s2 = r_r.sw_s1;
    r_nxt.rz_s1 = radiation_zone;
    r_nxt.rz_s2 = r_r.rz_s1;
    r_nxt.qd_s1 = q_data_seen;
    r_nxt.qd_s2 = r_r.qd_s1;

    // Millisecond divider and boundary counters
    ms_evt = (r_r.div == DIVW'(MS_CYC - 1));
    sec_evt = ms_evt && (r_r.ms == MS_LAST);
    r_nxt.div = ms_evt ? '0 : r_r.div + 1'b1;
    r_nxt.ms_tick = ms_evt;
    r_nxt.fsec = sec_evt;
    r_nxt.f21 = 1'b0;
    r_nxt.f100 = 1'b0;
    if (ms_evt) begin
      r_nxt.ms = (r_r.ms == MS_LAST) ? 10'h000 : r_r.ms + 10'h001;
      r_nxt.c21 = (r_r.c21 == CNT21_LAST) ? 5'h00 : r_r.c21 + 5'h01;
      r_nxt.f21 = (r_r.c21 == CNT21_LAST);
    end
    if (sec_evt) begin
      r_nxt.sec = r_r.sec + 32'h0000_0001;
      r_nxt.c100 = (r_r.c100 == CNT100_LAST) ? 7'h00 : r_r.c100 + 7'h01;
      r_nxt.f100 = (r_r.c100 == CNT100_LAST);
    end
    r_nxt.sec_stb = sec_evt && (r_r.st != ST_START);

    // AXI write before decode, so a telecommand in the same cycle wins
    if (s_axi_awvalid && r_r.awready) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_r.wready) begin
      r_nxt.w_got = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (r_r.aw_got && r_r.w_got && !r_r.bvalid) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = mapped(r_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (r_r.awaddr == A_CFG && r_r.wstrb[0]) begin
        r_nxt.cmd_en = r_r.wdata[0];
        r_nxt.ecc_en = r_r.wdata[1];
        r_nxt.wdog_en = r_r.wdata[2];
        r_nxt.proc_hold = r_r.wdata[3];
      end
    end
    r_nxt.awready = !r_nxt.aw_got && !r_nxt.bvalid;
    r_nxt.wready = !r_nxt.w_got && !r_nxt.bvalid;

    // AXI read, answered one cycle after the address is taken
    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_r.arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        A_TIME_SEC: r_nxt.rdata = r_r.sec;
        A_TIME_MS: r_nxt.rdata = {22'h00_0000, r_r.ms};
        A_CFG: r_nxt.rdata = {28'h000_0000, r_r.proc_hold, r_r.wdog_en, r_r.ecc_en, r_r.cmd_en};
        A_STATUS: r_nxt.rdata = {16'h0000, 8'(r_r.cnt), r_r.rz_s2, r_r.wd_restart, r_r.ovf, r_r.pend, r_r.alive};
        A_HK: r_nxt.rdata = {16'h0000, r_r.hk};
        A_QSTAT0: r_nxt.rdata = {16'h0000, r_r.q_stat[0]};
        A_QSTAT1: r_nxt.rdata = {16'h0000, r_r.q_stat[1]};
        A_QSTAT2: r_nxt.rdata = {16'h0000, r_r.q_stat[2]};
        A_QSTAT3: r_nxt.rdata = {16'h0000, r_r.q_stat[3]};
        default: r_nxt.rdata = 32'h0000_0000;
      endcase
    end
    r_nxt.arready = !r_nxt.rvalid;

    // Sequencer: startup, decode at the second, init commands
    case (r_r.st)
      ST_START: begin
        r_nxt.start_cnt = r_r.start_cnt + 2'h1;
        if (r_r.start_cnt == 2'(START_WAIT)) begin
          r_nxt.st = ST_IDLE;
          r_nxt.wd_restart = (r_r.sw_s2[WDC_MSB:WDC_LSB] != 5'h00);
          if (r_r.sw_s2[WDC_MSB:WDC_LSB] != 5'h00) begin
            // Watchdog restart: saved flags, telemetry and status words come back
            r_nxt.cmd_en = keep_r.cmd_en;
            r_nxt.ecc_en = keep_r.ecc_en;
            r_nxt.wdog_en = keep_r.wdog_en;
            r_nxt.proc_hold = keep_r.proc_hold;
            r_nxt.alive = keep_r.alive;
            r_nxt.streak = keep_r.streak;
            r_nxt.q_stat = keep_r.q_stat;
            r_nxt.hk = keep_r.hk;
          end
        end
      end
      ST_IDLE: begin
        if (sec_evt && r_r.pend) begin
          r_nxt.pend = 1'b0;
          if (r_r.held[31:20] == TC_PREFIX) begin
            case (r_r.held[19:16])
              Z_Q0: zmap = 4'h1;
              Z_Q1: zmap = 4'h2;
              Z_Q2: zmap = 4'h4;
              Z_Q3: zmap = 4'h8;
              Z_ALL: zmap = 4'hF;
              default: zmap = 4'h0;
            endcase
            fmap = zmap & r_r.alive;
            if (r_r.held[19:16] == Z_HWCFG && lo[15:8] == 8'h00) begin
              case (lo[7:0])
                HW_PROC_RESET: r_nxt.proc_hold = 1'b1;
                HW_PROC_RELEASE: r_nxt.proc_hold = 1'b0;
                HW_QCMD_ON: r_nxt.cmd_en = 1'b1;
                HW_QCMD_OFF: r_nxt.cmd_en = 1'b0;
                HW_ECC_ON: r_nxt.ecc_en = 1'b1;
                HW_ECC_OFF: r_nxt.ecc_en = 1'b0;
                HW_WDOG_ON: r_nxt.wdog_en = 1'b1;
                HW_WDOG_OFF: r_nxt.wdog_en = 1'b0;
                default: r_nxt.proc_hold = r_r.proc_hold;
              endcase
            end else if (r_r.cmd_en && fmap != 4'h0 && !(lo == QC_HV_ON && r_r.rz_s2)) begin
              push = 1'b1;
              push_ent = {fmap, (lo == QC_INIT) ? QC_RST_REL : lo};
              for (int i = 0; i < 4; i++) begin
                if (fmap[i]) begin
                  r_nxt.q_stat[i] = lo;
                end
              end
              if (lo == QC_INIT) begin
                r_nxt.init_map = fmap;
                r_nxt.st = ST_INIT1;
              end
            end
          end
        end
      end
      ST_INIT1: begin
        if (!full) begin
          push = 1'b1;
          push_ent = {r_r.init_map, QC_DET_EVENT};
          r_nxt.st = ST_INIT2;
        end
      end
      ST_INIT2: begin
        if (!full) begin
          push = 1'b1;
          push_ent = {r_r.init_map, QC_FEB_EVENT};
          r_nxt.st = ST_IDLE;
        end
      end
      default: r_nxt.st = ST_START;
    endcase

    // Arrival is sensed at each tick; a new one overwrites the held word
    if (ms_evt && r_r.arrived) begin
      r_nxt.held = r_r.arr_word;
      r_nxt.pend = 1'b1;
      r_nxt.arrived = 1'b0;
    end
    if (r_r.tc_s2 && !r_r.tc_s3) begin
      r_nxt.arrived = 1'b1;
      r_nxt.arr_word = r_r.tw_s2;
    end

    // Command queue: a decode push into a full queue is dropped and flagged; init pushes wait for space
    push_ok = push && !full;
    pop = ms_evt && (r_r.cnt != '0);
    if (push_ok) begin
      r_nxt.q_mem[r_r.wp] = push_ent;
      r_nxt.wp = r_r.wp + 1'b1;
    end else if (push) begin
      r_nxt.ovf = 1'b1;
    end
    r_nxt.q_stb = 4'h0;
    if (pop) begin
      r_nxt.q_word = r_r.q_mem[r_r.rp][15:0];
      r_nxt.q_stb = r_r.q_mem[r_r.rp][19:16];
      r_nxt.rp = r_r.rp + 1'b1;
    end
    r_nxt.cnt = r_r.cnt + (PW+1)'(push_ok) - (PW+1)'(pop);

    // Quadrant liveness judged once per second from seen data
    r_nxt.seen = r_r.seen | r_r.qd_s2;
    if (sec_evt) begin
      r_nxt.seen = 4'h0;
      for (int i = 0; i < 4; i++) begin
        if (r_r.seen[i] || r_r.qd_s2[i]) begin
          r_nxt.streak[i] = (r_r.streak[i] == ALIVE_SECS) ? ALIVE_SECS : r_r.streak[i] + 2'h1;
          r_nxt.alive[i] = (r_r.streak[i] + 2'h1 >= ALIVE_SECS);
        end else begin
          r_nxt.streak[i] = 2'h0;
          r_nxt.alive[i] = 1'b0;
        end
        if (r_nxt.alive[i] != r_r.alive[i]) begin
          r_nxt.hk[15:8] = r_nxt.hk[15:8] + 8'h01;
        end
      end
      r_nxt.hk[3:0] = r_nxt.alive;
    end
  end

  // Power-on clears telemetry, status words and the rest, but sets cmd_en, ecc_en and wdog_en
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      r_r <= '0;
      r_r.st <= ST_START;
      r_r.cmd_en <= CMD_EN_RST;
      r_r.ecc_en <= ECC_EN_RST;
      r_r.wdog_en <= WDOG_EN_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Saved copy refreshed each second; no reset so it survives a restart
  assign save_en = sec_evt && (r_r.st != ST_START);
  always_ff @(posedge ref_clk) begin
    if (save_en) begin
      keep_r <= {r_r.cmd_en, r_r.ecc_en, r_r.wdog_en, r_r.proc_hold, r_r.alive, r_r.streak, r_r.q_stat, r_r.hk};
    end
  end

  // Outputs straight from flops
  assign q_cmd_stb = r_r.q_stb;
  assign q_cmd_word = r_r.q_word;
  assign sec_cmd_stb = r_r.sec_stb;
  assign ms_tick = r_r.ms_tick;
  assign flag_21ms = r_r.f21;
  assign flag_sec = r_r.fsec;
  assign flag_100s = r_r.f100;
  assign sys_time = r_r.sec;
  assign quad_cmd_en = r_r.cmd_en;
  assign ecc_en = r_r.ecc_en;
  assign wdog_en = r_r.wdog_en;
  assign proc_hold = r_r.proc_hold;
  assign s_axi_awready = r_r.awready;
  assign s_axi_wready = r_r.wready;
  assign s_axi_bresp = r_r.bresp;
  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_arready = r_r.arready;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;
  assign s_axi_rvalid = r_r.rvalid;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  sequence s_init_start;
    r_r.st == ST_IDLE && r_nxt.st == ST_INIT1 && r_r.cnt < (QDEPTH - 2);
  endsequence
  sequence s_init_rest;
    (r_r.st == ST_INIT1 && push_ok && push_ent[15:0] == QC_DET_EVENT) ##1
    (r_r.st == ST_INIT2 && push_ok && push_ent[15:0] == QC_FEB_EVENT);
  endsequence

  a_ms_wrap: assert property (ms_evt && r_r.ms == MS_LAST |=> r_r.ms == 10'h000)
    else $error("ms counter did not wrap");
  a_sec_count: assert property (sec_evt |=> r_r.sec == $past(r_r.sec) + 32'h0000_0001)
    else $error("second count did not advance");
  a_bound_21: assert property (r_r.f21 |-> $past(ms_evt) && $past(r_r.c21) == CNT21_LAST)
    else $error("21 ms flag at wrong time");
  a_flag_sec: assert property (sec_evt |=> r_r.fsec && r_r.ms_tick && r_r.ms == 10'h000)
    else $error("second flag missing");
  a_tc_hold: assert property (r_r.pend && !ms_evt |=> r_r.held == $past(r_r.held))
    else $error("held command changed between ticks");
  a_route_gate: assert property (push_ok && r_r.st == ST_IDLE |-> (push_ent[19:16] & ~r_r.alive) == 4'h0 && r_r.cmd_en)
    else $error("command queued for dead quadrant or while disabled");
  a_hv_block: assert property (push_ok && push_ent[15:0] == QC_HV_ON |-> !r_r.rz_s2)
    else $error("hv on queued in radiation zone");
  a_one_per_ms: assert property (r_r.q_stb != 4'h0 |-> $past(ms_evt) && $past(r_r.cnt) != '0)
    else $error("quadrant command sent off tick");
  // A watchdog restart may bring a live quadrant back straight from the saved copy
  a_alive_rise: assert property ($rose(r_r.alive[0]) |-> ($past(sec_evt) && $past(r_r.streak[0]) != 2'h0) ||
    ($past(r_r.st) == ST_START && keep_r.alive[0]))
    else $error("quadrant alive without two data seconds");
  a_decode_sec: assert property (r_r.st == ST_IDLE && r_nxt.st == ST_INIT1 |-> sec_evt)
    else $error("decode off the second boundary");
  a_init_order: assert property (s_init_start |=> s_init_rest)
    else $error("init sequence out of order");
  a_wdog_restore: assert property (r_r.st == ST_START && r_nxt.st == ST_IDLE && r_r.sw_s2[WDC_MSB:WDC_LSB] != 5'h00
    |=> r_r.wd_restart ##1 r_r.wd_restart)
    else $error("watchdog restart not recognised");
endmodule

// ### verification/tcd_partner.sv
`timescale 1ns/1ps
// Bus management unit and four quadrants on the far side of the block
module tcd_partner (
  // Clock
  input wire logic ref_clk,
  // Per-second command from the block
  input wire logic sec_cmd_stb,
  // Quadrants that answer with data
  input wire logic [3:0] alive_mask,
  // Lines into the block
  output logic tc_strobe,
  output logic [31:0] tc_word,
  output logic [3:0] q_data_seen
);
  logic [1:0] ans_cnt;
  initial begin
    tc_strobe = 1'b0;
    tc_word = 32'h0000_0000;
    q_data_seen = 4'h0;
    ans_cnt = 2'h0;
  end
  // Word is steady around the strobe, then the bus shows junk; the tc task keeps sends 2 s apart
  task automatic send(input logic [31:0] w);
    @(posedge ref_clk) tc_word <= w;
    @(posedge ref_clk) tc_strobe <= 1'b1;
    repeat (8) @(posedge ref_clk);
    tc_strobe <= 1'b0;
    repeat (6) @(posedge ref_clk);
    tc_word <= ~w;
  endtask
  // Live quadrants answer each per-second command with a short data pulse
  always @(posedge ref_clk) begin
    if (sec_cmd_stb) ans_cnt <= 2'h2;
    else if (ans_cnt != 2'h0) ans_cnt <= ans_cnt - 2'h1;
    q_data_seen <= (ans_cnt != 2'h0) ? alive_mask : 4'h0;
  end
endmodule

// ### verification/telecommand_dispatch_timebase_test.sv
`timescale 1ns/1ps
module telecommand_dispatch_timebase_test;
  import tcd_pkg::*;
  // Short millisecond keeps the run near 80k cycles
  localparam int MSC = 2;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic tc_strobe;
  logic [31:0] tc_word;
  logic [15:0] status_word = 16'h0000;
  logic radiation_zone = 1'b0;
  logic [3:0] q_data_seen, q_cmd_stb;
  logic [15:0] q_cmd_word;
  logic sec_cmd_stb, ms_tick, flag_21ms, flag_sec, flag_100s, quad_cmd_en, ecc_en, wdog_en, proc_hold;
  logic [31:0] sys_time, s_axi_rdata;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] alive_mask = 4'h7;
  logic [19:0] exp_q[$];
  int errors = 0;
  int comparisons = 0;

  tcd_top #(.MS_CYC(MSC)) tcd_top_inst (.ref_clk, .rstn, .tc_strobe, .tc_word, .status_word, .radiation_zone,
    .q_data_seen, .q_cmd_stb, .q_cmd_word, .sec_cmd_stb, .ms_tick, .flag_21ms, .flag_sec, .flag_100s,
    .sys_time, .quad_cmd_en, .ecc_en, .wdog_en, .proc_hold, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tcd_partner tcd_partner_inst (.ref_clk, .sec_cmd_stb, .alive_mask, .tc_strobe, .tc_word, .q_data_seen);

  always #20 ref_clk = ~ref_clk;

  task automatic wrap_up();
    $display("Counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A wait that ran out ends the run
  task automatic hang();
    chk(36'h0, 36'h1);
    wrap_up();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (++n > 50) hang();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (++n > 50) hang();
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata & m}, {er, ed});
  endtask
  task automatic wait_sec(input int k);
    int n;
    n = 0;
    repeat (k) begin
      do begin
        @(posedge ref_clk);
        if (++n > 1100 * MSC * k) hang();
      end while (!flag_sec);
    end
  endtask
  // Send, then keep the sender's two-second spacing
  task automatic tc(input logic [31:0] w);
    tcd_partner_inst.send(w);
    wait_sec(2);
  endtask

  // Every quadrant strobe must match the oldest note and land on a tick
  always @(posedge ref_clk) begin
    if (rstn && flag_100s) chk(sys_time % 100, 0);
    if (rstn && q_cmd_stb !== 4'h0) begin
      if (exp_q.size() == 0) chk({1'b1, q_cmd_stb, q_cmd_word}, 36'h0);
      else chk({ms_tick, q_cmd_stb, q_cmd_word}, {1'b1, exp_q.pop_front()});
    end
  end

  initial begin
    #(40 * 98000);
    hang();
  end

  initial begin
    logic [7:0] codes[8] = '{8'h00, 8'h01, 8'h21, 8'h20, 8'h31, 8'h30, 8'h41, 8'h40};
    logic [3:0] zs[4] = '{4'h2, 4'h4, 4'h6, 4'h8};
    logic [3:0] cfg, m;
    logic [15:0] r, r0;
    logic [31:0] t0;
    int n, k, s, b;
    void'($urandom(32'hebcaf4a4));
    // Power-on start: restart count field kept zero
    status_word <= 16'($urandom) & 16'hc1ff;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    axi_rd(A_CFG, 32'hf, 32'h7, RESP_OKAY);
    axi_rd(A_QSTAT2, 32'hffff, 32'h0, RESP_OKAY);
    axi_rd(8'h40, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'h5, RESP_SLVERR);
    axi_wr(A_TIME_SEC, 32'h5, RESP_OKAY);
    axi_wr(A_CFG, 32'h5, RESP_OKAY);
    chk({quad_cmd_en, ecc_en, wdog_en}, 3'b101);
    axi_wr(A_CFG, 32'h7, RESP_OKAY);
    $display("done: register access");
    // Ticks per second, 21 ms spacing, one per-second command
    wait_sec(1);
    n = 0;
    k = 0;
    s = 0;
    t0 = 0;
    do begin
      @(posedge ref_clk);
      n += int'(ms_tick);
      s += int'(sec_cmd_stb);
      if (n == 500) t0 = sys_time;
      if (flag_21ms) begin
        if (k != 0) chk(n - k, 21);
        k = n;
      end
    end while (!flag_sec && n < 2000);
    chk(n, 1000);
    chk(s, 1);
    repeat (20) @(posedge ref_clk);
    chk(sys_time, t0 + 1);
    $display("done: timebase");
    wait_sec(2);
    axi_rd(A_STATUS, 32'hf, 32'h7, RESP_OKAY);
    // Quadrant selectors, masked by liveness
    foreach (zs[i]) begin
      r = {4'h1, 12'($urandom)};
      m = (zs[i] == Z_ALL) ? 4'hf : 4'h1 << zs[i][3:1];
      m = m & alive_mask;
      if (m != 4'h0) exp_q.push_back({m, r});
      tc({TC_PREFIX, zs[i], r});
    end
    axi_rd(A_QSTAT1, 32'hffff, {16'h0, r}, RESP_OKAY);
    axi_rd(A_QSTAT3, 32'hffff, 32'h0, RESP_OKAY);
    exp_q.push_back({4'h1, QC_RST_REL});
    exp_q.push_back({4'h1, QC_DET_EVENT});
    exp_q.push_back({4'h1, QC_FEB_EVENT});
    tc({16'hc000, QC_INIT});
    $display("done: detector commands");
    // High-voltage-on dropped inside the radiation zone, others pass
    radiation_zone <= 1'b1;
    tc({16'hc008, QC_HV_ON});
    axi_rd(A_STATUS, 32'h80, 32'h80, RESP_OKAY);
    r0 = {4'h2, 12'($urandom)};
    exp_q.push_back({4'h1, r0});
    tc({16'hc000, r0});
    radiation_zone <= 1'b0;
    alive_mask <= 4'h3;
    wait_sec(2);
    axi_rd(A_STATUS, 32'hf, 32'h3, RESP_OKAY);
    $display("done: radiation zone and liveness");
    // Each hardware configuration code in turn
    cfg = 4'h7;
    foreach (codes[i]) begin
      b = (codes[i][7:4] == 4'h0) ? 3 : int'(codes[i][7:4]) - 2;
      cfg[b] = ~codes[i][0];
      tc({16'hc00a, 8'h00, codes[i]});
      chk({proc_hold, wdog_en, ecc_en, quad_cmd_en}, cfg);
      if (codes[i] == HW_QCMD_OFF) tc({16'hc000, 16'h0123});
    end
    axi_rd(A_QSTAT0, 32'hffff, {16'h0, r0}, RESP_OKAY);
    axi_rd(A_CFG, 32'hf, {28'h0, cfg}, RESP_OKAY);
    $display("done: configuration");
    // A second word before the boundary replaces the first
    r = {4'h3, 12'($urandom)};
    exp_q.push_back({4'h2, r});
    tcd_partner_inst.send(32'hc002_1111);
    tc({16'hc002, r});
    chk(exp_q.size(), 0);
    $display("done: replacement");
    // Watchdog restart: saved flags and status words come back after a mid-run reset
    axi_wr(A_CFG, 32'h2, RESP_OKAY);
    wait_sec(1);
    rstn <= 1'b0;
    status_word <= 16'h0200 | (16'($urandom) & 16'hc1ff);
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    axi_rd(A_CFG, 32'hf, 32'h2, RESP_OKAY);
    axi_rd(A_QSTAT1, 32'hffff, {16'h0, r}, RESP_OKAY);
    axi_rd(A_STATUS, 32'h4f, 32'h43, RESP_OKAY);
    $display("done: watchdog restart");
    wrap_up();
  end
endmodule
